// ---- asq_defines.svh ----
// constants of the amplifier mode sequencer: register offsets, bit positions, timing counts
// included by the package and by every design file
`ifndef ASQ_DEFINES_SVH
`define ASQ_DEFINES_SVH

// ==========================================================
// register byte offsets
`define ASQ_OFS_CTRL 4'h0
`define ASQ_OFS_VOLUME 4'h4
`define ASQ_OFS_STATUS 4'h8
`define ASQ_OFS_MASK 4'hc

// ==========================================================
// control register fields
`define ASQ_CTRL_SHUTDOWN_BIT 0
`define ASQ_CTRL_SLEEP_BIT 1
`define ASQ_CTRL_MUTE_BIT 4
`define ASQ_CTRL_SPEED_BIT 6
`define ASQ_CTRL_RESET 8'h00

// ==========================================================
// status register fields
`define ASQ_ST_OT_BIT 0
`define ASQ_ST_DC_BIT 1
`define ASQ_ST_OC_BIT 2
`define ASQ_ST_ACTIVE_BIT 3
`define ASQ_ST_OFF_BIT 4
`define ASQ_FAULT_W 3
`define ASQ_EVENT_W 5

// ==========================================================
// volume codes, 9 bits, quarter-dB per code
`define ASQ_VOL_W 9
`define ASQ_VOL_MIN 9'h00e
`define ASQ_VOL_RESET 9'h19e
`define ASQ_VOL_STEP 9'h001

// ==========================================================
// timing
`define ASQ_SLOW_FRAMES 4'h8
`define ASQ_POWER_UP_NS 1000
`define ASQ_ACTIVE_NS 2000
`define ASQ_CLK_NS 10
`define ASQ_POWER_UP_CYC 16'((`ASQ_POWER_UP_NS + `ASQ_CLK_NS - 1) / `ASQ_CLK_NS)
`define ASQ_ACTIVE_CYC 16'((`ASQ_ACTIVE_NS + `ASQ_CLK_NS - 1) / `ASQ_CLK_NS)
`endif

// ---- asq_host.sv ----
// host-side model: shutdown pin and frame clock ticks
// assumes the bench commands the pin level through pin_cmd
`timescale 1ns/1ns
module asq_host
#(
	parameter int FRAME_CYC = 4
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pin_cmd,
	output logic shutdown_request_n,
	output logic frame_tick
);
	logic [7:0] cnt_r;
	// ==========================================================
	// pin: host toggles it low to clear a latched fault
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			shutdown_request_n <= 1'b0;
		else
			shutdown_request_n <= pin_cmd;
	// ==========================================================
	// frame clock, short period keeps ramps quick
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			cnt_r <= 8'h00;
			frame_tick <= 1'b0;
		end
		else
		begin
			cnt_r <= (cnt_r == 8'(FRAME_CYC - 1)) ? 8'h00 : cnt_r + 8'h01;
			frame_tick <= (cnt_r == 8'h00);
		end
endmodule

// ---- asq_pkg.sv ----
// types of the amplifier mode sequencer
// assumes asq_defines.svh on the include path
`include "asq_defines.svh"
package asq_pkg;
	typedef enum logic [2:0] {
		ASQ_OFF, ASQ_POWER_UP, ASQ_SLEEP, ASQ_START, ASQ_RAMP, ASQ_PLAY, ASQ_STOP
	} asq_state_type;

	typedef struct packed {
		logic power_on;
		logic switching;
		logic out_hiz_n;
	} asq_power_type;
endpackage

// ---- asq_ramp.sv ----
// volume ramp: moves the level one quarter-dB step toward a target per frame tick, or per eighth frame tick when slow
// assumes frame_tick is a one-cycle pulse per frame-clock period
`timescale 1ns/1ns
`include "asq_defines.svh"
module asq_ramp
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic frame_tick,
	input wire logic slow,
	input wire logic [`ASQ_VOL_W-1:0] target,
	output logic [`ASQ_VOL_W-1:0] level,
	output logic at_target
);
	import asq_pkg::*;

	// ==========================================================
	// frame divider
	logic [3:0] div_r;
	logic step;

	always_comb
	begin
		step = frame_tick && (!slow || div_r == 4'h0);
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			div_r <= 4'h0;
		else if (frame_tick)
			div_r <= (div_r == `ASQ_SLOW_FRAMES - 4'h1) ? 4'h0 : div_r + 4'h1;
	end

	// ==========================================================
	// level
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			level <= `ASQ_VOL_MIN;
		else if (step && level < target)
			level <= level + `ASQ_VOL_STEP;
		else if (step && level > target)
			level <= level - `ASQ_VOL_STEP;
	end

	assign at_target = (level == target);
endmodule

// ---- asq_regs.sv ----
// avalon-mm register slave: control, volume, status and mask
// assumes a master that holds its request until waitrequest is low
`timescale 1ns/1ns
`include "asq_defines.svh"
module asq_regs
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [`ASQ_EVENT_W-1:0] events,
	input wire logic fault_clear,
	input wire logic [`ASQ_ST_OFF_BIT:0] live,
	output logic [7:0] ctrl,
	output logic [`ASQ_VOL_W-1:0] volume,
	output logic [`ASQ_FAULT_W-1:0] faults,
	output logic irq
);
	import asq_pkg::*;

	logic ack_r;
	logic [`ASQ_EVENT_W-1:0] status_r;
	logic [`ASQ_EVENT_W-1:0] mask_r;
	logic rd_st;

	// ==========================================================
	// one wait state per access, so read data come from a register
	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	assign rd_st = avs_read && !ack_r && avs_address == `ASQ_OFS_STATUS;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ack_r <= 1'b0;
		else
			ack_r <= (avs_read || avs_write) && !ack_r;
	end

	// ==========================================================
	// writable registers, never touched by shutdown
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl <= `ASQ_CTRL_RESET;
			volume <= `ASQ_VOL_RESET;
			mask_r <= '0;
		end
		// writes land at the edge where waitrequest is seen low
		else if (avs_write && ack_r)
		begin
			if (avs_address == `ASQ_OFS_CTRL)
				ctrl <= avs_writedata[7:0];
			if (avs_address == `ASQ_OFS_VOLUME)
				volume <= avs_writedata[`ASQ_VOL_W-1:0];
			if (avs_address == `ASQ_OFS_MASK)
				mask_r <= avs_writedata[`ASQ_EVENT_W-1:0];
		end
	end

	// ==========================================================
	// sticky events: set wins over clear
	// fault bits leave only on shutdown toggle, not on a read
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			status_r <= '0;
		else
		begin
			status_r[`ASQ_FAULT_W-1:0] <= events[`ASQ_FAULT_W-1:0] |
				(fault_clear ? '0 : status_r[`ASQ_FAULT_W-1:0]);
			status_r[`ASQ_EVENT_W-1:`ASQ_FAULT_W] <= events[`ASQ_EVENT_W-1:`ASQ_FAULT_W] |
				(rd_st ? '0 : status_r[`ASQ_EVENT_W-1:`ASQ_FAULT_W]);
		end
	end

	assign faults = status_r[`ASQ_FAULT_W-1:0];
	assign irq = |(status_r & mask_r);

	// ==========================================================
	// read data
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			avs_readdata <= '0;
		else if (avs_read && !ack_r)
		begin
			unique case (avs_address)
				`ASQ_OFS_CTRL: avs_readdata <= {24'h000000, ctrl};
				`ASQ_OFS_VOLUME: avs_readdata <= {23'h000000, volume};
				`ASQ_OFS_STATUS: avs_readdata <= {27'h0000000, status_r | live};
				`ASQ_OFS_MASK: avs_readdata <= {27'h0000000, mask_r};
				default: avs_readdata <= 32'h00000000;
			endcase
		end
	end
endmodule

// ---- asq_sequencer.sv ----
// mode sequencer of a mono class-d amplifier: shutdown, sleep, mute, play
// assumes fault and frame inputs synchronous to clk; one clock domain
// Function
// - shutdown holds while the pin is low or the shutdown bit is zero, and ends only when both are high.
// - in shutdown the power stage is off and the speaker outputs are high impedance.
// - registers stay reachable and keep their values through shutdown entry and exit, except the three fault flags, which entry clears.
// - a latched fault stays set until shutdown has gone low, which the host must toggle to clear it.
// - leaving shutdown first powers up the internal analog and digital blocks.
// - the power stage is powered and switching starts only while the sleep bit is zero.
// - with switching started and mute zero, the volume ramps to the programmed level and audio plays.
// - shutdown during play ramps down, then stops switching and sets high impedance in the same cycle, then powers down.
// - ramps move in quarter-dB steps each frame period or each eighth, by the ramp speed bit.
// - after the activation delay switching starts and the volume ramps from -100 dB upward.
// - a shutdown toggle clears only the three fault flags and no other register.
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
`include "asq_defines.svh"
module asq_sequencer
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic shutdown_request_n,
	input wire logic frame_tick,
	input wire logic over_temperature_flag,
	input wire logic over_current_flag,
	input wire logic dc_offset_flag,
	output asq_pkg::asq_power_type power,
	output logic [`ASQ_VOL_W-1:0] volume_level,
	output logic audio_play,
	output logic fault_n,
	output logic irq
);
	import asq_pkg::*;

	asq_state_type state_r;
	logic [15:0] wait_r;
	logic [7:0] ctrl;
	logic [`ASQ_VOL_W-1:0] volume;
	logic [`ASQ_FAULT_W-1:0] faults;
	logic [`ASQ_EVENT_W-1:0] events;
	logic shutdown;
	logic sleep_req;
	logic fault_any;
	logic shutdown_r;
	logic fault_clear;
	logic [`ASQ_VOL_W-1:0] target;
	logic at_target;
	logic [`ASQ_VOL_W-1:0] level;
	logic was_active_r;

	// ==========================================================
	// request decode
	assign shutdown = !shutdown_request_n || !ctrl[`ASQ_CTRL_SHUTDOWN_BIT];
	assign fault_any = |faults;
	// a latched fault acts as a forced sleep until cleared
	assign sleep_req = ctrl[`ASQ_CTRL_SLEEP_BIT] || fault_any;
	assign fault_clear = shutdown && !shutdown_r;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			shutdown_r <= 1'b1;
		else
			shutdown_r <= shutdown;
	end

	// ==========================================================
	// volume target: floor unless playing unmuted
	always_comb
	begin
		target = `ASQ_VOL_MIN;
		if ((state_r == ASQ_RAMP || state_r == ASQ_PLAY) && !shutdown && !sleep_req
			&& !ctrl[`ASQ_CTRL_MUTE_BIT])
			target = volume;
	end

	// ==========================================================
	// mode state machine
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r <= ASQ_OFF;
			wait_r <= 16'h0000;
		end
		else
		begin
			unique case (state_r)
				ASQ_OFF:
					if (!shutdown)
					begin
						state_r <= ASQ_POWER_UP;
						wait_r <= `ASQ_POWER_UP_CYC;
					end
				ASQ_POWER_UP:
					if (shutdown)
						state_r <= ASQ_OFF;
					else if (wait_r > 16'h0001)
						wait_r <= wait_r - 16'h0001;
					else
						state_r <= ASQ_SLEEP;
				ASQ_SLEEP:
					if (shutdown)
						state_r <= ASQ_OFF;
					else if (!sleep_req)
					begin
						state_r <= ASQ_START;
						wait_r <= `ASQ_ACTIVE_CYC;
					end
				ASQ_START:
					if (shutdown || sleep_req)
						state_r <= ASQ_STOP;
					else if (wait_r > 16'h0001)
						wait_r <= wait_r - 16'h0001;
					else
						state_r <= ASQ_RAMP;
				ASQ_RAMP:
					// requests are looked at again only once the ramp lands
					if (at_target)
						state_r <= (shutdown || sleep_req) ? ASQ_STOP : ASQ_PLAY;
				ASQ_PLAY:
					if (shutdown || sleep_req || !at_target)
						state_r <= ASQ_RAMP;
				ASQ_STOP:
					// entered from ASQ_RAMP or ASQ_START, the outputs still show that state here; switching stops and the outputs float together at the next edge
					state_r <= shutdown ? ASQ_OFF : ASQ_SLEEP;
				default:
					state_r <= ASQ_OFF;
			endcase
		end
	end

	// ==========================================================
	// power outputs
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			power <= '0;
		else
		begin
			power.power_on <= state_r != ASQ_OFF;
			power.switching <= state_r == ASQ_RAMP || state_r == ASQ_PLAY;
			power.out_hiz_n <= state_r == ASQ_RAMP || state_r == ASQ_PLAY || state_r == ASQ_START;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			volume_level <= `ASQ_VOL_MIN;
			audio_play <= 1'b0;
			was_active_r <= 1'b0;
		end
		else
		begin
			volume_level <= level;
			audio_play <= state_r == ASQ_PLAY && !ctrl[`ASQ_CTRL_MUTE_BIT];
			was_active_r <= state_r == ASQ_PLAY;
		end
	end

	assign fault_n = !fault_any;

	// ==========================================================
	// events: faults, entry to play, entry to shutdown
	assign events = {
		state_r == ASQ_OFF && !power.power_on == 1'b0,
		state_r == ASQ_PLAY && !was_active_r,
		over_current_flag,
		dc_offset_flag,
		over_temperature_flag
	};

	// ==========================================================
	// submodules
	asq_ramp u_ramp
	(
		.clk(clk),
		.reset_n(reset_n),
		.frame_tick(frame_tick),
		.slow(ctrl[`ASQ_CTRL_SPEED_BIT]),
		.target(target),
		.level(level),
		.at_target(at_target)
	);

	asq_regs u_regs
	(
		.clk(clk),
		.reset_n(reset_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.events(events),
		.fault_clear(fault_clear),
		.live(events),
		.ctrl(ctrl),
		.volume(volume),
		.faults(faults),
		.irq(irq)
	);
endmodule

// ---- asq_sequencer_chk.sv ----
// checker of the mode sequencer, bound to the top module
// assumes asq_pkg and asq_defines.svh compiled first
`timescale 1ns/1ns
`include "asq_defines.svh"
module asq_sequencer_chk
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic shutdown_request_n,
	input wire logic frame_tick,
	input wire asq_pkg::asq_power_type power,
	input wire logic [`ASQ_VOL_W-1:0] volume_level,
	input wire logic audio_play,
	input wire logic fault_n
);
	import asq_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// assertions
	a_off_is_hiz: assert property (!power.power_on |-> !power.out_hiz_n && !power.switching)
		else $error("outputs driven while powered down");
	a_switch_needs_power: assert property (power.switching |-> power.out_hiz_n && power.power_on)
		else $error("switching without power or drive");
	a_power_up_first: assert property ($rose(power.out_hiz_n) |-> power.power_on && $past(power.power_on, 8))
		else $error("stage started before blocks powered");
	a_ramp_from_floor: assert property ($rose(power.switching) |-> volume_level == `ASQ_VOL_MIN)
		else $error("ramp did not start at floor");
	a_quarter_step: assert property ($changed(volume_level) |->
		(volume_level - $past(volume_level) == 9'h001) || ($past(volume_level) - volume_level == 9'h001))
		else $error("volume moved more than one step");
	a_step_on_frame: assert property ($changed(volume_level) |-> $past(frame_tick, 2))
		else $error("volume moved without frame tick");
	a_play_needs_switch: assert property (audio_play |-> power.switching && power.out_hiz_n)
		else $error("play without switching stage");
	a_fault_held: assert property (!fault_n && shutdown_request_n && !avs_write && !$past(avs_write) |=> !fault_n)
		else $error("fault cleared without shutdown");
	a_fault_sleeps: assert property ($fell(fault_n) |-> ##[0:300] !power.switching)
		else $error("fault did not stop switching");
	a_pin_shuts: assert property ($fell(shutdown_request_n) |-> ##[1:1000] !power.power_on)
		else $error("pin low did not reach shutdown");
	a_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait");
endmodule
bind asq_sequencer asq_sequencer_chk asq_sequencer_chk_inst (.clk(clk), .reset_n(reset_n), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .shutdown_request_n(shutdown_request_n),
	.frame_tick(frame_tick), .power(power), .volume_level(volume_level), .audio_play(audio_play),
	.fault_n(fault_n));

// ---- test_amp_shutdown_mode_sequencer.sv ----
// self-checking bench of the mode sequencer
// assumes asq_pkg, the design, the checker and the host model compiled first
`timescale 1ns/1ns
`include "asq_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module test_amp_shutdown_mode_sequencer;
	import asq_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic pin_cmd = 1'b1;
	logic shutdown_request_n;
	logic frame_tick;
	logic [2:0] flt = 3'h0;
	asq_power_type power;
	logic [8:0] volume_level;
	logic audio_play;
	logic fault_n;
	logic irq;
	logic [31:0] q;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	int n;
	asq_sequencer asq_sequencer_inst (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .shutdown_request_n(shutdown_request_n), .frame_tick(frame_tick),
		.over_temperature_flag(flt[0]), .over_current_flag(flt[2]), .dc_offset_flag(flt[1]), .power(power),
		.volume_level(volume_level), .audio_play(audio_play), .fault_n(fault_n), .irq(irq));
	asq_host #(.FRAME_CYC(4)) asq_host_inst (.clk(clk), .reset_n(reset_n), .pin_cmd(pin_cmd),
		.shutdown_request_n(shutdown_request_n), .frame_tick(frame_tick));
	// ==========================================================
	// clock and hang guard
	initial
	begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			mismatches++;
			test_done();
		end
	end
	// ==========================================================
	// tasks
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wait_play();
		n = 0;
		while (audio_play !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic wait_off();
		n = 0;
		while (power.power_on !== 1'b0 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial
	begin
		reset_n <= 1'b0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		`CHK(power, 3'b000)
		`CHK(volume_level, `ASQ_VOL_MIN)
		`CHK({fault_n, irq}, 2'b10)
		bus(1'b0, `ASQ_OFS_CTRL, 32'h0);
		`CHK(q, 32'h0)
		bus(1'b0, `ASQ_OFS_VOLUME, 32'h0);
		`CHK(q, 32'h0000019e)
		bus(1'b0, 4'h2, 32'h0);
		`CHK(q, 32'h0)
		repeat (400) @(posedge clk);
		`CHK(power.power_on, 1'b0)
		$display("test reset done");
		bus(1'b1, `ASQ_OFS_VOLUME, 32'h014);
		bus(1'b0, `ASQ_OFS_VOLUME, 32'h0);
		`CHK(q, 32'h00000014)
		bus(1'b1, `ASQ_OFS_MASK, 32'h08);
		bus(1'b1, `ASQ_OFS_CTRL, 32'h01);
		wait_play();
		`CHK({power, volume_level}, {3'b111, 9'h014})
		`CHK(irq, 1'b1)
		bus(1'b0, `ASQ_OFS_STATUS, 32'h0);
		`CHK(q[3], 1'b1)
		@(posedge clk);
		`CHK(irq, 1'b0)
		$display("test power up done");
		bus(1'b1, `ASQ_OFS_CTRL, 32'h11);
		repeat (100) @(posedge clk);
		`CHK({volume_level, audio_play, power.switching}, {`ASQ_VOL_MIN, 2'b01})
		bus(1'b1, `ASQ_OFS_CTRL, 32'h13);
		repeat (300) @(posedge clk);
		`CHK({power.power_on, power.switching}, 2'b10)
		bus(1'b1, `ASQ_OFS_CTRL, 32'h41);
		wait_play();
		`CHK(n >= 192, 1'b1)
		$display("test mute sleep done");
		bus(1'b1, `ASQ_OFS_CTRL, 32'h01);
		for (int i = 0; i < 3; i++)
		begin
			flt <= 3'h1 << i;
			@(posedge clk);
			flt <= 3'h0;
			repeat (300) @(posedge clk);
			`CHK({fault_n, power.switching}, 2'b00)
			bus(1'b0, `ASQ_OFS_STATUS, 32'h0);
			bus(1'b0, `ASQ_OFS_STATUS, 32'h0);
			`CHK(q[2:0], 3'h1 << i)
			pin_cmd <= 1'b0;
			wait_off();
			`CHK(power, 3'b000)
			pin_cmd <= 1'b1;
			bus(1'b0, `ASQ_OFS_CTRL, 32'h0);
			`CHK(q, 32'h00000001)
			bus(1'b0, `ASQ_OFS_STATUS, 32'h0);
			`CHK({q[2:0], fault_n}, 4'h1)
			wait_play();
			`CHK(volume_level, 9'h014)
		end
		$display("test faults done");
		bus(1'b1, `ASQ_OFS_CTRL, 32'h00);
		wait_off();
		`CHK({power, volume_level}, {3'b000, `ASQ_VOL_MIN})
		$display("test shutdown done");
		test_done();
	end
endmodule
